// *** logic/acc_conv_ctrl.sv ***
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module acc_conv_ctrl
   import acc_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  ce_i,
   // apb slave
   input  wire logic                  psel_i,
   input  wire logic                  penable_i,
   input  wire logic                  pwrite_i,
   input  wire logic [ACC_ADDR_W-1:0] paddr_i,
   input  wire logic [31:0]           pwdata_i,
   input  wire logic [3:0]            pstrb_i,
   output logic [31:0]                prdata_o,
   output logic                       pready_o,
   output logic                       pslverr_o,
   // device side
   input  wire logic                  sleep_i,
   input  wire logic                  special_trigger_i,
   input  wire logic                  rc_clk_i,
   input  wire logic                  cmp_i,
   output logic [6:0]                 channel_enable_o,
   output logic [6:0]                 pin_analog_o,
   output logic                       ref_pos_ext_o,
   output logic                       ref_neg_ext_o,
   output logic                       converter_power_o,
   output logic                       sample_connect_o,
   output logic [9:0]                 trial_code_o,
   output logic                       conversion_done_flag_o
);

   import acc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // justify a ten-bit result into the high/low pair
   function automatic logic [15:0] justify(input logic [9:0] r, input logic right);
      if (right)
         justify = {6'h00, r};
      else
         justify = {r, 6'h00};
   endfunction : justify

   ////////////////////////////////////////////////////////////////////////////
   // register state
   logic [1:0] conv_clock_sel;
   logic [2:0] channel_sel;
   logic       go_busy;
   logic       converter_on;
   logic       result_justify;
   logic       conv_clock_halve;
   logic [1:0] ref_config;
   logic [6:0] pin_analog_bits;
   logic [7:0] result_high_byte;
   logic [7:0] result_low_byte;

   ////////////////////////////////////////////////////////////////////////////
   // synchronisers: the first stage feeds only the second stage
   logic rc_meta;
   logic rc_sync;
   // comparator answers our own registered trial code: one latch stage only,
   // a second would hand the divide-by-two clock the previous trial's answer
   logic cmp_sync;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rc_meta  <= 1'b0;
         rc_sync  <= 1'b0;
         cmp_sync <= 1'b0;
      end
      else if (ce_i)
      begin
         rc_meta  <= rc_clk_i;
         rc_sync  <= rc_meta;
         cmp_sync <= cmp_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   wire logic [7:0] word_idx  = paddr_i[ACC_ADDR_W-1:2];
   wire logic       hit_c0    = (word_idx == ACC_IDX_CONTROL_ZERO);
   wire logic       hit_analog_pin_select = (word_idx == ACC_IDX_ANALOG_PIN_SEL);
   wire logic       hit_c1    = (word_idx == ACC_IDX_CONTROL_ONE);
   wire logic       hit_rh    = (word_idx == ACC_IDX_RESULT_HIGH);
   wire logic       hit_rl    = (word_idx == ACC_IDX_RESULT_LOW);
   wire logic       mapped    = hit_c0 | hit_analog_pin_select | hit_c1 | hit_rh | hit_rl;
   wire logic       access    = psel_i & penable_i & ce_i;
   wire logic       bad_addr  = ~mapped | (paddr_i[1:0] != 2'h0);
   // only byte lane 0 carries implemented bits
   wire logic       wr_ok     = access & pwrite_i & ~bad_addr & pstrb_i[0];
   wire logic       wr_c0     = wr_ok & hit_c0;
   wire logic       wr_c1     = wr_ok & hit_c1;
   wire logic       wr_analog_pin_select  = wr_ok & hit_analog_pin_select;
   wire logic       wr_rh     = wr_ok & hit_rh;
   wire logic       wr_rl     = wr_ok & hit_rl;
   wire logic [7:0] wbyte     = pwdata_i[7:0];

   wire logic [7:0] rd_c0 = {conv_clock_sel, channel_sel, go_busy, 1'b0, converter_on};
   wire logic [7:0] rd_c1 = {result_justify, conv_clock_halve, ref_config, 4'h0};
   wire logic [7:0] rd_analog_pin_select = {1'b0, pin_analog_bits};
   wire logic [7:0] rd_byte =
      hit_c0    ? rd_c0 :
      hit_c1    ? rd_c1 :
      hit_analog_pin_select ? rd_analog_pin_select :
      hit_rh    ? result_high_byte :
      hit_rl    ? result_low_byte : 8'h00;

   // zero wait states while ce_i is high; error on unmapped or misaligned words
   assign pready_o  = ce_i;
   assign pslverr_o = psel_i & penable_i & bad_addr;
   assign prdata_o  = (psel_i & ~pwrite_i & ~bad_addr) ? {24'h000000, rd_byte} : 32'h00000000;

   ////////////////////////////////////////////////////////////////////////////
   // power and abort conditions
   wire logic rc_selected = (conv_clock_sel == ACC_CLK_SEL_RC);
   // sleep keeps running only on rc
   // sleep on divided clock powers down
   wire logic conv_active = converter_on & ~(sleep_i & ~rc_selected);
   wire logic trig_start  = special_trigger_i & conv_active;

   wire logic       sar_busy;
   wire logic       sar_run;
   wire logic       sar_sample;
   wire logic       sar_done;
   wire logic [9:0] sar_trial;
   wire logic [9:0] sar_result;
   wire logic       tad_tick;

   wire logic sar_abort = sar_busy & (~go_busy | ~conv_active);
   wire logic sar_start = go_busy & conv_active;
   wire logic [15:0] justified = justify(sar_result, result_justify);

   ////////////////////////////////////////////////////////////////////////////
   // control register zero, go bit
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         conv_clock_sel <= ACC_RST_CONTROL_ZERO[ACC_C0_CLK_SEL_LSB +: 2];
         channel_sel    <= ACC_RST_CONTROL_ZERO[ACC_C0_CHAN_LSB +: 3];
         converter_on   <= ACC_RST_CONTROL_ZERO[ACC_C0_ON_BIT];
      end
      else if (wr_c0)
      begin
         conv_clock_sel <= wbyte[ACC_C0_CLK_SEL_LSB +: 2];
         channel_sel    <= wbyte[ACC_C0_CHAN_LSB +: 3];
         converter_on   <= wbyte[ACC_C0_ON_BIT];
      end
   end

   // set sources win over the completion clear in the same cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         go_busy <= ACC_RST_CONTROL_ZERO[ACC_C0_GO_BIT];
      else if (ce_i)
      begin
         // abort clears go, on bit untouched
         if (!conv_active)
            go_busy <= 1'b0;
         else if (trig_start)
            go_busy <= 1'b1;
         else if (wr_c0)
            go_busy <= wbyte[ACC_C0_GO_BIT];
         else if (sar_done)
            go_busy <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control register one and analog select
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         result_justify   <= ACC_RST_CONTROL_ONE[ACC_C1_JUSTIFY_BIT];
         conv_clock_halve <= ACC_RST_CONTROL_ONE[ACC_C1_HALVE_BIT];
         ref_config       <= ACC_RST_CONTROL_ONE[ACC_C1_REF_LSB +: 2];
         pin_analog_bits  <= ACC_RST_ANALOG_PINS;
      end
      else
      begin
         if (wr_c1)
         begin
            result_justify   <= wbyte[ACC_C1_JUSTIFY_BIT];
            conv_clock_halve <= wbyte[ACC_C1_HALVE_BIT];
            ref_config       <= wbyte[ACC_C1_REF_LSB +: 2];
         end
         if (wr_analog_pin_select)
            pin_analog_bits <= wbyte[6:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // result pair: completion load wins over a software write
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         result_high_byte <= ACC_RST_RESULT;
         result_low_byte  <= ACC_RST_RESULT;
      end
      else if (ce_i)
      begin
         if (sar_done)
         begin
            result_high_byte <= justified[15:8];
            result_low_byte  <= justified[7:0];
         end
         else
         begin
            if (wr_rh)
               result_high_byte <= wbyte;
            if (wr_rl)
               result_low_byte <= wbyte;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // conversion clock and sequencer
   // divided or rc tick
   acc_tad_gen u_tad_gen
   (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .run_i      (sar_run),
      .clk_sel_i  (conv_clock_sel),
      .halve_i    (conv_clock_halve),
      .rc_level_i (rc_sync),
      .tick_o     (tad_tick)
   );

   acc_sar_seq u_sar_seq
   (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .ce_i     (ce_i),
      .start_i  (sar_start),
      .abort_i  (sar_abort),
      .tick_i   (tad_tick),
      .cmp_i    (cmp_sync),
      .busy_o   (sar_busy),
      .run_o    (sar_run),
      .sample_o (sar_sample),
      .done_o   (sar_done),
      .trial_o  (sar_trial),
      .result_o (sar_result)
   );

   ////////////////////////////////////////////////////////////////////////////
   // analog side controls
   // one-hot channel route, code 111 selects none
   assign channel_enable_o = (channel_sel < 3'(ACC_CHANNELS)) ?
                             7'(7'h01 << channel_sel) : 7'h00;
   assign pin_analog_o     = pin_analog_bits;
   assign ref_pos_ext_o    = ref_config[1];
   assign ref_neg_ext_o    = ref_config[0];
   assign converter_power_o = conv_active;
   assign sample_connect_o  = sar_sample & conv_active;
   assign trial_code_o      = sar_trial;
   assign conversion_done_flag_o = sar_done;

endmodule : acc_conv_ctrl

// *** logic/acc_pkg.sv ***
package acc_pkg;

   // register indices; byte address on the bus is four times the index
   localparam logic [7:0] ACC_IDX_CONTROL_ZERO   = 8'h1f;
   localparam logic [7:0] ACC_IDX_ANALOG_PIN_SEL = 8'h9b;
   localparam logic [7:0] ACC_IDX_CONTROL_ONE    = 8'h9f;
   localparam logic [7:0] ACC_IDX_RESULT_HIGH    = 8'h1e;
   localparam logic [7:0] ACC_IDX_RESULT_LOW     = 8'h9e;

   localparam int unsigned ACC_ADDR_W = 10;

   // control register zero fields
   localparam int unsigned ACC_C0_CLK_SEL_LSB = 6;
   localparam int unsigned ACC_C0_CHAN_LSB    = 3;
   localparam int unsigned ACC_C0_GO_BIT      = 2;
   localparam int unsigned ACC_C0_ON_BIT      = 0;

   // control register one fields
   localparam int unsigned ACC_C1_JUSTIFY_BIT = 7;
   localparam int unsigned ACC_C1_HALVE_BIT   = 6;
   localparam int unsigned ACC_C1_REF_LSB     = 4;

   // reset values
   localparam logic [7:0] ACC_RST_CONTROL_ZERO = 8'h00;
   localparam logic [7:0] ACC_RST_CONTROL_ONE  = 8'h00;
   localparam logic [6:0] ACC_RST_ANALOG_PINS  = 7'h7f;
   localparam logic [7:0] ACC_RST_RESULT       = 8'h00;

   // clock select code that picks the internal rc clock
   localparam logic [1:0] ACC_CLK_SEL_RC = 2'h3;

   // conversion timing in conversion-clock periods, plus result width and channel count
   localparam int unsigned ACC_RESULT_BITS = 10;
   localparam int unsigned ACC_CONV_TADS   = 9;
   localparam int unsigned ACC_HOLD_TADS   = 2;
   localparam int unsigned ACC_CHANNELS    = 7;

endpackage : acc_pkg

// *** logic/acc_tad_gen.sv ***
`timescale 1ns/1ps

// conversion-clock tick: system clock divided down, or rising edges of the
// already synchronised rc oscillator
module acc_tad_gen
   import acc_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   input  wire logic       run_i,
   input  wire logic [1:0] clk_sel_i,
   input  wire logic       halve_i,
   input  wire logic       rc_level_i,
   output logic            tick_o
);

   // divide ratio from the select code and the halve bit
   function automatic logic [6:0] tad_div(input logic [1:0] sel, input logic halve);
      logic [6:0] base;
      base = 7'h02;
      unique case (sel)
         2'h0:    base = 7'h02;
         2'h1:    base = 7'h08;
         default: base = 7'h20;
      endcase
      tad_div = halve ? 7'(base << 1) : base;
   endfunction : tad_div

   logic [6:0] count;
   logic       rc_prev;

   wire logic       use_rc   = (clk_sel_i == ACC_CLK_SEL_RC);
   wire logic [6:0] div_last = 7'(tad_div(clk_sel_i, halve_i) - 7'h01);
   wire logic       rc_rise  = rc_level_i & ~rc_prev;
   // at or past the end point: a ratio cut mid-period must not let the count wrap
   wire logic       div_tick = run_i & ~use_rc & (count >= div_last);

   assign tick_o = use_rc ? (run_i & rc_rise) : div_tick;

   // counter restarts while idle so the first segment never exceeds one period
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         count   <= 7'h00;
         rc_prev <= 1'b0;
      end
      else if (ce_i)
      begin
         rc_prev <= rc_level_i;
         if (!run_i || div_tick)
            count <= 7'h00;
         else
            count <= 7'(count + 7'h01);
      end
   end

endmodule : acc_tad_gen

// *** logic/acc_sar_seq.sv ***
`timescale 1ns/1ps

// successive-approximation sequencer: ten decisions, then a hold-off
module acc_sar_seq
   import acc_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   input  wire logic       start_i,
   input  wire logic       abort_i,
   input  wire logic       tick_i,
   input  wire logic       cmp_i,
   output logic            busy_o,
   output logic            run_o,
   output logic            sample_o,
   output logic            done_o,
   output logic [9:0]      trial_o,
   output logic [9:0]      result_o
);

   typedef enum logic [1:0]
   {
      ACC_SAR_IDLE = 2'b00,
      ACC_SAR_CONV = 2'b01,
      ACC_SAR_HOLD = 2'b10
   } acc_sar_state_e;

   acc_sar_state_e state;
   logic [3:0]     bit_idx;
   logic [1:0]     hold_cnt;
   logic           armed;

   wire logic [9:0] cur_mask = 10'(10'h001 << bit_idx);
   wire logic [9:0] kept     = cmp_i ? trial_o : (trial_o & ~cur_mask);
   wire logic       last_bit = (bit_idx == 4'h0);

   assign busy_o   = (state == ACC_SAR_CONV);
   assign run_o    = (state != ACC_SAR_IDLE);
   assign sample_o = (state == ACC_SAR_IDLE);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state    <= ACC_SAR_IDLE;
         bit_idx  <= 4'h0;
         hold_cnt <= 2'h0;
         armed    <= 1'b0;
         done_o   <= 1'b0;
         trial_o  <= 10'h000;
         result_o <= 10'h000;
      end
      else if (ce_i)
      begin
         done_o <= 1'b0;
         unique case (state)
            ACC_SAR_IDLE:
            begin
               if (start_i)
               begin
                  state   <= ACC_SAR_CONV;
                  bit_idx <= 4'(ACC_RESULT_BITS - 1);
                  trial_o <= 10'h200;
                  armed   <= 1'b0;
               end
            end
            ACC_SAR_CONV:
            begin
               // comparator latch has not yet seen the top trial in the first cycle
               armed <= 1'b1;
               if (abort_i)
               begin
                  state    <= ACC_SAR_HOLD;
                  hold_cnt <= 2'h0;
               end
               // first partial segment plus nine periods
               else if (tick_i && armed)
               begin
                  if (last_bit)
                  begin
                     result_o <= kept;
                     done_o   <= 1'b1;
                     state    <= ACC_SAR_HOLD;
                     hold_cnt <= 2'h0;
                  end
                  else
                  begin
                     trial_o <= kept | (cur_mask >> 1);
                     bit_idx <= 4'(bit_idx - 4'h1);
                  end
               end
            end
            ACC_SAR_HOLD:
            begin
               if (tick_i)
               begin
                  if (hold_cnt == 2'(ACC_HOLD_TADS - 1))
                     state <= ACC_SAR_IDLE;
                  else
                     hold_cnt <= 2'(hold_cnt + 2'h1);
               end
            end
            default:
               state <= ACC_SAR_IDLE;
         endcase
      end
   end

endmodule : acc_sar_seq

// *** testbench/acc_conv_ctrl_assertions.sv ***
`timescale 1ns/1ps

module acc_conv_ctrl_assertions
   import acc_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [9:0]  paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0]  pstrb_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic [6:0]  channel_enable_o,
   input wire logic [6:0]  pin_analog_o,
   input wire logic        ref_pos_ext_o,
   input wire logic        ref_neg_ext_o,
   input wire logic        converter_power_o,
   input wire logic        sample_connect_o,
   input wire logic        conversion_done_flag_o
);
   localparam logic [9:0] A_C0  = {ACC_IDX_CONTROL_ZERO, 2'b00};
   localparam logic [9:0] A_C1  = {ACC_IDX_CONTROL_ONE, 2'b00};
   localparam logic [9:0] A_SEL = {ACC_IDX_ANALOG_PIN_SEL, 2'b00};
   logic rd;
   logic wr;
   assign rd = psel_i & penable_i & ~pwrite_i;
   assign wr = psel_i & penable_i & pready_o & pwrite_i & pstrb_i[0];
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////
   property p_flag_pulse;
      conversion_done_flag_o |=> !conversion_done_flag_o;
   endproperty
   a_flag_pulse: assert property (p_flag_pulse)
      else $error("done flag held too long");
   // shortest hold-off is two periods of the divide-by-two clock
   property p_hold;
      conversion_done_flag_o |=> !sample_connect_o [*3];
   endproperty
   a_hold: assert property (p_hold)
      else $error("sampling reconnected too early");
   property p_off_flag;
      !converter_power_o ##1 !converter_power_o |-> !conversion_done_flag_o;
   endproperty
   a_off_flag: assert property (p_off_flag)
      else $error("done flag while powered down");
   // abort must beat a tick that lands while power is cut
   property p_pwr_abort;
      !converter_power_o |=> !conversion_done_flag_o;
   endproperty
   a_pwr_abort: assert property (p_pwr_abort)
      else $error("done flag after power cut");
   property p_chan;
      wr && paddr_i == A_C0 && pwdata_i[5:3] != 3'h7
         |=> channel_enable_o == 7'h1 << $past(pwdata_i[5:3]);
   endproperty
   a_chan: assert property (p_chan)
      else $error("channel route wrong");
   property p_c1_zero;
      rd && paddr_i == A_C1 |-> prdata_o[3:0] == 4'h0 && prdata_o[31:8] == 24'h0;
   endproperty
   a_c1_zero: assert property (p_c1_zero)
      else $error("unused control one bits read nonzero");
   property p_sel_zero;
      rd && paddr_i == A_SEL |-> prdata_o[31:7] == 25'h0;
   endproperty
   a_sel_zero: assert property (p_sel_zero)
      else $error("unused analog select bit read nonzero");
   property p_pin;
      wr && paddr_i == A_SEL |=> pin_analog_o == $past(pwdata_i[6:0]);
   endproperty
   a_pin: assert property (p_pin)
      else $error("pin analog bits not updated");
   property p_ref;
      wr && paddr_i == A_C1 |=> {ref_pos_ext_o, ref_neg_ext_o} == $past(pwdata_i[5:4]);
   endproperty
   a_ref: assert property (p_ref)
      else $error("reference select not updated");
   property p_reset;
      $fell(rst_i) |-> pin_analog_o == 7'h7f && !converter_power_o && channel_enable_o == 7'h1;
   endproperty
   a_reset: assert property (p_reset)
      else $error("outputs wrong after reset");
   c_done: cover property (conversion_done_flag_o);
   c_sel: cover property (wr && paddr_i == A_SEL);
   c_pwr: cover property ($fell(converter_power_o));
endmodule : acc_conv_ctrl_assertions

bind acc_conv_ctrl acc_conv_ctrl_assertions u_acc_chk (
   .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .channel_enable_o(channel_enable_o),
   .pin_analog_o(pin_analog_o), .ref_pos_ext_o(ref_pos_ext_o),
   .ref_neg_ext_o(ref_neg_ext_o), .converter_power_o(converter_power_o),
   .sample_connect_o(sample_connect_o), .conversion_done_flag_o(conversion_done_flag_o));

// *** testbench/test_adc_conversion_control.sv ***
`timescale 1ns/1ps

module test_adc_conversion_control;
   import acc_pkg::*;
   localparam logic [9:0] A_C0  = {ACC_IDX_CONTROL_ZERO, 2'b00};
   localparam logic [9:0] A_C1  = {ACC_IDX_CONTROL_ONE, 2'b00};
   localparam logic [9:0] A_SEL = {ACC_IDX_ANALOG_PIN_SEL, 2'b00};
   localparam logic [9:0] A_HI  = {ACC_IDX_RESULT_HIGH, 2'b00};
   localparam logic [9:0] A_LO  = {ACC_IDX_RESULT_LOW, 2'b00};
   typedef struct {logic [9:0] a; logic [3:0] s; logic [7:0] d; logic [7:0] x;} acc_reg_row_s;
   typedef struct {logic [1:0] sel; logic hv; logic js; logic [1:0] vr;
                   logic [9:0] vin; int dv;} acc_conv_row_s;
   acc_reg_row_s  regs [9] = '{'{A_C1, 4'hf, 8'hff, 8'hf0}, '{A_C1, 4'hf, 8'h00, 8'h00},
      '{A_SEL, 4'hf, 8'h80, 8'h00}, '{A_SEL, 4'hf, 8'hff, 8'h7f},
      '{A_SEL, 4'he, 8'h00, 8'h7f}, '{A_C0, 4'hf, 8'hfe, 8'hf8},
      '{A_C0, 4'hf, 8'h00, 8'h00}, '{A_HI, 4'hf, 8'h12, 8'h12}, '{A_LO, 4'hf, 8'h34, 8'h34}};
   // divider in system clocks; the rc row uses the bench oscillator period
   acc_conv_row_s cv [7] = '{'{2'h0, 1'b0, 1'b1, 2'h0, 10'h2a5, 2},
      '{2'h1, 1'b0, 1'b0, 2'h1, 10'h3ff, 8}, '{2'h2, 1'b0, 1'b1, 2'h2, 10'h000, 32},
      '{2'h0, 1'b1, 1'b0, 2'h3, 10'h155, 4}, '{2'h1, 1'b1, 1'b1, 2'h0, 10'h001, 16},
      '{2'h2, 1'b1, 1'b0, 2'h1, 10'h200, 64}, '{2'h3, 1'b0, 1'b1, 2'h2, 10'h3fe, 8}};
   logic        clk_i, rst_i, ce_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic        sleep_i, special_trigger_i, rc_clk_i, ref_pos_ext_o, ref_neg_ext_o;
   logic        converter_power_o, sample_connect_o, conversion_done_flag_o, e;
   logic [9:0]  paddr_i, trial_code_o, vin;
   logic [31:0] pwdata_i, prdata_o;
   logic [3:0]  pstrb_i;
   logic [6:0]  channel_enable_o, pin_analog_o;
   logic [7:0]  q, c0;
   wire logic   cmp_i;
   int          fail_count, tests_run, n;
   int          rc_cnt = 0;
   // analog comparator: input sits half a code above vin, so no ties
   assign cmp_i = ({vin, 1'b1} > {trial_code_o, 1'b0});
   acc_conv_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .sleep_i(sleep_i), .special_trigger_i(special_trigger_i), .rc_clk_i(rc_clk_i),
      .cmp_i(cmp_i), .channel_enable_o(channel_enable_o), .pin_analog_o(pin_analog_o),
      .ref_pos_ext_o(ref_pos_ext_o), .ref_neg_ext_o(ref_neg_ext_o),
      .converter_power_o(converter_power_o), .sample_connect_o(sample_connect_o),
      .trial_code_o(trial_code_o), .conversion_done_flag_o(conversion_done_flag_o));
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
   begin
      rc_cnt <= rc_cnt + 1;
      rc_clk_i <= rc_cnt[2];
   end
   ////////////////////////////////////////////////////////////
   task test_done;
      $display("checks %0d errors %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      tests_run++;
      if (g !== x)
      begin
         $display("[ERR] %s expected %h seen %h", nm, x, g);
         fail_count++;
      end
   endtask : chk
   task apb(input logic w, input logic [9:0] a, input logic [3:0] s, input logic [7:0] d);
      int k;
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pstrb_i <= s;
      pwdata_i <= {24'h0, d};
      @(posedge clk_i);
      penable_i <= 1'b1;
      k = 0;
      @(posedge clk_i);
      while (pready_o !== 1'b1 && k < 50)
      begin
         @(posedge clk_i);
         k++;
      end
      if (k == 50)
      begin
         chk("pready", 1, 0);
         test_done();
      end
      q = prdata_o[7:0];
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(negedge clk_i);
   endtask : apb
   task wr(input logic [9:0] a, input logic [7:0] d);
      apb(1'b1, a, 4'hf, d);
   endtask : wr
   task rdc(input string nm, input logic [9:0] a, input logic [7:0] x);
      apb(1'b0, a, 4'hf, 8'h00);
      chk(nm, 32'(x), 32'(q));
   endtask : rdc
   // a hang here is caught by the caller comparing n with the bound
   task wait_flag(input int lim);
      n = 0;
      while (conversion_done_flag_o !== 1'b1 && n < lim)
      begin
         @(posedge clk_i);
         n++;
      end
   endtask : wait_flag
   task pulse;
      @(posedge clk_i);
      special_trigger_i <= 1'b1;
      @(posedge clk_i);
      special_trigger_i <= 1'b0;
   endtask : pulse
   ////////////////////////////////////////////////////////////
   initial
   begin
      {rst_i, ce_i, psel_i, penable_i, pwrite_i, sleep_i, special_trigger_i} = 7'h20;
      rst_i = 1'b1;
      {paddr_i, pwdata_i, pstrb_i, vin} = '0;
      {fail_count, tests_run} = '0;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (regs[i])
      begin
         apb(1'b1, regs[i].a, regs[i].s, regs[i].d);
         rdc("reg", regs[i].a, regs[i].x);
      end
      wr(A_SEL, 8'h7f);
      foreach (cv[i])
      begin
         vin = cv[i].vin;
         wr(A_C1, {cv[i].js, cv[i].hv, cv[i].vr, 4'h0});
         chk("ref", 32'(cv[i].vr), {30'h0, ref_pos_ext_o, ref_neg_ext_o});
         c0 = {cv[i].sel, 3'(i), 3'b001};
         wr(A_C0, c0);
         chk("chan", 32'(7'h1 << i), 32'(channel_enable_o));
         repeat (4 * cv[i].dv) @(posedge clk_i);
         wr(A_C0, c0 | 8'h04);
         wait_flag(1000);
         chk("time", 1, 32'(n >= 9 * cv[i].dv && n <= 10 * cv[i].dv + 6));
         rdc("go", A_C0, c0);
         rdc("hi", A_HI, cv[i].js ? {6'h0, vin[9:8]} : vin[9:2]);
         rdc("lo", A_LO, cv[i].js ? vin[7:0] : {vin[1:0], 6'h0});
      end
      wr(A_HI, 8'h5a);
      wr(A_LO, 8'ha5);
      wr(A_C0, 8'h4d);
      repeat (30) @(posedge clk_i);
      wr(A_C0, 8'h49);
      wait_flag(150);
      chk("abort", 150, n);
      rdc("abort hi", A_HI, 8'h5a);
      rdc("abort lo", A_LO, 8'ha5);
      wr(A_C0, 8'h04);
      chk("off power", 0, converter_power_o);
      pulse();
      wait_flag(60);
      chk("off trig", 60, n);
      rdc("off go", A_C0, 8'h00);
      wr(A_C0, 8'h01);
      repeat (8) @(posedge clk_i);
      pulse();
      rdc("trig go", A_C0, 8'h05);
      wait_flag(60);
      chk("trig done", 1, 32'(n < 60));
      repeat (10) @(posedge clk_i);
      wr(A_C0, 8'h05);
      @(posedge clk_i);
      sleep_i <= 1'b1;
      wait_flag(60);
      chk("sleep abort", 60, n);
      chk("sleep power", 0, converter_power_o);
      rdc("sleep on", A_C0, 8'h01);
      wr(A_C0, 8'hc1);
      chk("rc power", 1, converter_power_o);
      wr(A_C0, 8'hc5);
      wait_flag(200);
      chk("rc sleep", 1, 32'(n < 200));
      sleep_i <= 1'b0;
      wr(A_C0, 8'h38);
      chk("chan7", 0, 32'(channel_enable_o));
      @(posedge clk_i);
      ce_i <= 1'b0;
      @(negedge clk_i);
      chk("freeze", 0, pready_o);
      @(posedge clk_i);
      ce_i <= 1'b1;
      apb(1'b0, 10'h004, 4'hf, 8'h00);
      chk("unmapped", 1, e);
      apb(1'b1, 10'h07d, 4'hf, 8'h00);
      chk("misaligned", 1, e);
      rdc("kept", A_C0, 8'h38);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rdc("rst c0", A_C0, ACC_RST_CONTROL_ZERO);
      rdc("rst c1", A_C1, ACC_RST_CONTROL_ONE);
      rdc("rst sel", A_SEL, {1'b0, ACC_RST_ANALOG_PINS});
      rdc("rst hi", A_HI, ACC_RST_RESULT);
      test_done();
   end
endmodule : test_adc_conversion_control
